/* hdl/oled_params.svh */
// Command codes, field positions, reset values and timing constants
`ifndef OLED_PARAMS_SVH
`define OLED_PARAMS_SVH

`define CMD_DESELECT      8'hdb
`define CMD_PERIOD        8'hdc
`define CMD_DIVIDE        8'hd5
`define CMD_RMW_ENTER     8'he0
`define CMD_RMW_END       8'hee
`define CMD_COL_LO_NIB    4'h0
`define CMD_COL_HI_NIB    4'h1
`define CMD_PAGE_TOP      5'h16

`define DESELECT_RESET    8'h35
`define PERIOD_RESET      8'h01
`define DIVIDE_RESET      2'h0
`define NONOVERLAP_STEP   7'h03
`define FLOAT_ONE_CODE    3'h4
`define FLOAT_TWO_CODE    3'h7
`define DUMMY_BYTE        8'h00
`define CHIP_IDENT        6'h0c  // Arbitrary value, names no part

`define DIV_RATIO_0       5'h08
`define DIV_RATIO_1       5'h10
`define DIV_RATIO_2       5'h03
`define DIV_RATIO_3       5'h04

`define OSC_PERIOD_NS     5
`define MCLK_PERIOD_NS    5
`define OSC_TICKS         (`OSC_PERIOD_NS / `MCLK_PERIOD_NS)

`endif

/* hdl/oled_pkg.sv */
// Types shared by the command interpreter and its display memory
package oled_pkg;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_DESEL  = 2'b01,
      ST_PERIOD = 2'b10,
      ST_DIVIDE = 2'b11
   } cmd_state_t;
   typedef logic [9:0] ram_addr_t;
   typedef logic [6:0] column_t;
   typedef logic [2:0] page_t;
endpackage

/* hdl/oled_ram_if.sv */
// Carrier between the command interpreter and the display memory
`timescale 1ns/10ps
`default_nettype none
interface oled_ram_if;
   import oled_pkg::*;
   logic      we;
   ram_addr_t addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* hdl/oled_display_ram.sv */
// Display memory, eight pages of 128 bytes with registered read
`timescale 1ns/10ps
`default_nettype none
module oled_display_ram
   import oled_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Memory port
   oled_ram_if.mem  port
);
   logic [7:0] cells [0:1023];
   logic [7:0] rdata;

   // Read-before-write gives old data on a colliding access
   always_ff @(posedge mclk) begin
      if (port.we) begin
         cells[port.addr] <= port.wdata;
      end
      rdata <= cells[port.addr];
   end
   assign port.rdata = rdata;
endmodule
`default_nettype wire

/* hdl/oled_cmd_rmw_ram_access.sv */
// Command interpreter with read-modify-write display memory access
`timescale 1ns/10ps
`default_nettype none
`include "oled_params.svh"
module oled_cmd_rmw_ram_access
   import oled_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Host port pins
   input  wire logic       hostWrite,
   input  wire logic       hostRead,
   input  wire logic       cmd_data_select,
   input  wire logic       serialMode,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] dataOut,
   output logic            dataOutEnN,
   // Display state
   input  wire logic       displayOn,
   // Settings
   output logic      [7:0] deselectLevel,
   output logic      [7:0] periodByte,
   output logic      [6:0] rowNonOverlapClks,
   output logic      [1:0] segment_float_period,
   output logic            divided_display_clock,
   output logic            rmwActive,
   output logic      [6:0] column,
   output logic      [2:0] page
);
   logic       wrMeta, wrSync, wrPrev;
   logic       rdMeta, rdSync, rdPrev;
   logic       selMeta, selSync;
   logic       serMeta, serSync;
   logic [7:0] datMeta, datSync;
   cmd_state_t state, next_state;
   column_t    savedCol;
   logic [1:0] divCode;
   logic [4:0] divCnt;
   logic       rdPend, dummyDue, driving;
   oled_ram_if ramBus ();
   function automatic logic [4:0] divRatio(input logic [1:0] code);
      case (code)
         2'h0:    divRatio = `DIV_RATIO_0;
         2'h1:    divRatio = `DIV_RATIO_1;
         2'h2:    divRatio = `DIV_RATIO_2;
         default: divRatio = `DIV_RATIO_3;
      endcase
   endfunction
   function automatic logic [1:0] floatDecode(input logic [2:0] code);
      case (code)
         `FLOAT_ONE_CODE: floatDecode = 2'h1;
         `FLOAT_TWO_CODE: floatDecode = 2'h2;
         default:         floatDecode = 2'h0;
      endcase
   endfunction
   // Pins are asynchronous to mclk, so each passes two flip-flops
   always_ff @(posedge mclk) begin
      wrMeta  <= hostWrite;
      wrSync  <= wrMeta;
      rdMeta  <= hostRead;
      rdSync  <= rdMeta;
      selMeta <= cmd_data_select;
      selSync <= selMeta;
      serMeta <= serialMode;
      serSync <= serMeta;
      datMeta <= dataIn;
      datSync <= datMeta;
      // Edge memory tracks through reset, so a held strobe gives no edge
      wrPrev  <= wrSync;
      rdPrev  <= rdSync;
   end
   wire wrEvt     = wrSync & ~wrPrev;
   wire rdEvt     = rdSync & ~rdPrev;
   wire cmdEvt    = wrEvt & ~selSync;
   wire dataWrEvt = wrEvt & selSync;
   wire statusEvt = rdEvt & ~selSync;
   wire dataRdEvt = rdEvt & selSync & ~serSync;
   wire idleCmd   = cmdEvt & (state == ST_IDLE);
   wire isColLo   = idleCmd & (datSync[7:4] == `CMD_COL_LO_NIB);
   wire isColHi   = idleCmd & (datSync[7:4] == `CMD_COL_HI_NIB);
   wire isPage    = idleCmd & (datSync[7:3] == `CMD_PAGE_TOP);
   wire isEnter   = idleCmd & (datSync == `CMD_RMW_ENTER);
   wire isEnd     = idleCmd & (datSync == `CMD_RMW_END);
   wire rdAdvance = rdPend & ~rmwActive;
   wire [7:0] statusByte = {1'b0, ~displayOn, `CHIP_IDENT};
   always_comb begin
      case (state)
         ST_IDLE: begin
            if (datSync == `CMD_DESELECT) begin
               next_state = ST_DESEL;
            end else if (datSync == `CMD_PERIOD) begin
               next_state = ST_PERIOD;
            end else if (datSync == `CMD_DIVIDE) begin
               next_state = ST_DIVIDE;
            end else begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else if (cmdEvt) begin
         state <= next_state;
      end
   end
   // Parameter bytes of the two-byte commands
   always_ff @(posedge mclk) begin
      if (rst) begin
         deselectLevel <= `DESELECT_RESET;
         periodByte    <= `PERIOD_RESET;
         divCode       <= `DIVIDE_RESET;
      end else if (cmdEvt) begin
         if (state == ST_DESEL) begin
            deselectLevel <= datSync;
         end
         if (state == ST_PERIOD) begin
            periodByte <= datSync;
         end
         if (state == ST_DIVIDE) begin
            divCode <= datSync[1:0];
         end
      end
   end
   assign rowNonOverlapClks = 7'(periodByte[4:0]) * `NONOVERLAP_STEP;
   assign segment_float_period = floatDecode(periodByte[7:5]);
   always_ff @(posedge mclk) begin
      if (rst) begin
         divCnt                <= 5'h00;
         divided_display_clock <= 1'b0;
      end else if (divCnt >= divRatio(divCode) - 5'h01) begin
         divCnt                <= 5'h00;
         divided_display_clock <= 1'b1;
      end else begin
         divCnt                <= divCnt + 5'h01;
         divided_display_clock <= 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         page <= 3'h0;
      end else if (isPage) begin
         page <= datSync[2:0];
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         rmwActive <= 1'b0;
         savedCol  <= 7'h00;
      end else if (isEnter) begin
         rmwActive <= 1'b1;
         savedCol  <= column;
      end else if (isEnd) begin
         rmwActive <= 1'b0;
      end
   end
   // Column priority: set, restore, writes, reads; never status
   always_ff @(posedge mclk) begin
      if (rst) begin
         column <= 7'h00;
      end else if (isColLo) begin
         column[3:0] <= datSync[3:0];
      end else if (isColHi) begin
         column[6:4] <= datSync[2:0];
      end else if (isEnd && rmwActive) begin
         column <= savedCol;
      end else if (dataWrEvt) begin
         column <= column + 7'h01;
      end else if (rdAdvance) begin
         column <= column + 7'h01;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         dummyDue <= 1'b1;
      end else if (isColLo || isColHi) begin
         dummyDue <= 1'b1;
      end else if (dataRdEvt) begin
         dummyDue <= 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdPend <= 1'b0;
      end else begin
         rdPend <= dataRdEvt & ~dummyDue;
      end
   end
   // Output byte; memory data arrives one cycle after the strobe edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         dataOut <= 8'h00;
      end else if (statusEvt) begin
         dataOut <= statusByte;
      end else if (dataRdEvt && dummyDue) begin
         dataOut <= `DUMMY_BYTE;
      end else if (rdPend) begin
         dataOut <= ramBus.rdata;
      end
   end
   // Bus is released on the clock after the synchronized read strobe rdSync goes low
   always_ff @(posedge mclk) begin
      if (rst) begin
         driving <= 1'b0;
      end else if (statusEvt || dataRdEvt) begin
         driving <= 1'b1;
      end else if (!rdSync) begin
         driving <= 1'b0;
      end
   end
   assign dataOutEnN = ~driving;
   assign ramBus.we    = dataWrEvt;
   assign ramBus.addr  = {page, column};
   assign ramBus.wdata = datSync;
   oled_display_ram memory (
      .mclk (mclk),
      .port (ramBus)
   );
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence rdNormal;
      dataRdEvt && !dummyDue && !rmwActive ##1 rdPend;
   endsequence
   sequence rdInMode;
      dataRdEvt && !dummyDue && rmwActive ##1 rdPend;
   endsequence
   a_desel_capture: assert property (cmdEvt && state == ST_DESEL |=>
      deselectLevel == $past(datSync)) else $error("deselect not stored");
   a_period_capture: assert property (cmdEvt && state == ST_PERIOD |=>
      periodByte == $past(datSync)) else $error("period not stored");
   a_overlap_scale: assert property (cmdEvt && state == ST_PERIOD |=>
      rowNonOverlapClks == 7'($past(datSync[4:0])) * 7'h03)
      else $error("non-overlap wrong");
   a_float_decode: assert property (cmdEvt && state == ST_PERIOD
      && datSync[7:5] == 3'h7 |=> segment_float_period == 2'h2)
      else $error("float period wrong");
   a_mode_enter: assert property (isEnter |=> rmwActive
      && savedCol == $past(column)) else $error("mode entry wrong");
   a_mode_read_hold: assert property (rdInMode |=>
      column == $past(column)) else $error("read moved column in mode");
   a_end_restore: assert property (isEnd && rmwActive |=> !rmwActive
      && column == $past(savedCol)) else $error("end did not restore");
   a_write_advance: assert property (dataWrEvt |=>
      column == $past(column) + 7'h01) else $error("write no advance");
   a_status_byte: assert property (statusEvt |=>
      dataOut == {1'b0, ~$past(displayOn), 6'h0c} && !dataOutEnN)
      else $error("status byte wrong");
   a_read_advance: assert property (rdNormal |=>
      column == $past(column) + 7'h01) else $error("read no advance");
   a_dummy_first: assert property (dataRdEvt && dummyDue |=>
      dataOut == 8'h00 && !rdPend ##1 !rdPend) else $error("no dummy read");
   a_serial_noread: assert property (rdEvt && selSync && serSync
      && !driving |=> dataOutEnN) else $error("serial read drove bus");
   a_divided_display_clock_spacing: assert property (divided_display_clock |=>
      !divided_display_clock [*2]) else $error("display clock too fast");
   a_page_load: assert property (isPage |=> page == $past(datSync[2:0]))
      else $error("page not loaded");
   a_status_hold: assert property (statusEvt |=> column == $past(column)
      && page == $past(page) && rmwActive == $past(rmwActive))
      else $error("status read changed state");
endmodule
`default_nettype wire

/* tb/host_model.sv */
// Host processor model on the host port
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // Clock
   input  wire logic       mclk,
   // Host pins
   output logic            hostWrite,
   output logic            hostRead,
   output logic            cmd_data_select,
   output logic      [7:0] dataIn,
   input  wire logic [7:0] dataOut,
   input  wire logic       dataOutEnN
);
   initial begin
      hostWrite = 1'b0;
      hostRead = 1'b0;
      cmd_data_select = 1'b0;
      dataIn = 8'h00;
   end
   // Strobes stay six cycles, three times the sync depth
   task automatic put(input logic sel, input logic [7:0] b);
      @(negedge mclk);
      cmd_data_select = sel;
      dataIn = b;
      repeat (2) @(negedge mclk);
      hostWrite = 1'b1;
      repeat (6) @(negedge mclk);
      hostWrite = 1'b0;
      repeat (3) @(negedge mclk);
      // Released bus shows the inverse so stale data never looks valid
      dataIn = ~b;
   endtask
   task automatic get(input logic sel, output logic [7:0] b,
                      output logic en);
      @(negedge mclk);
      cmd_data_select = sel;
      repeat (2) @(negedge mclk);
      hostRead = 1'b1;
      repeat (6) @(negedge mclk);
      b = dataOut;
      en = dataOutEnN;
      hostRead = 1'b0;
      repeat (6) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the command interpreter
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top;
   import oled_pkg::*;
   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic       serialMode = 1'b0;
   logic       displayOn = 1'b0;
   logic       hostWrite, hostRead, cmd_data_select, dataOutEnN, divClk;
   logic       rmwActive;
   logic [7:0] dataIn, dataOut, deselectLevel, periodByte;
   logic [6:0] rowNonOverlapClks, column;
   logic [1:0] segFloat;
   logic [2:0] page;
   logic [7:0] mem [ram_addr_t];
   int         miscompares = 0;
   int         num_checks = 0;
   int         cyc = 0;
   always #2.5 mclk = ~mclk;
   oled_cmd_rmw_ram_access uut (.mclk(mclk), .rst(rst),
      .hostWrite(hostWrite), .hostRead(hostRead),
      .cmd_data_select(cmd_data_select), .serialMode(serialMode),
      .dataIn(dataIn), .dataOut(dataOut), .dataOutEnN(dataOutEnN),
      .displayOn(displayOn), .deselectLevel(deselectLevel),
      .periodByte(periodByte), .rowNonOverlapClks(rowNonOverlapClks),
      .segment_float_period(segFloat), .divided_display_clock(divClk),
      .rmwActive(rmwActive), .column(column), .page(page));
   host_model host (.mclk(mclk), .hostWrite(hostWrite),
      .hostRead(hostRead), .cmd_data_select(cmd_data_select),
      .dataIn(dataIn), .dataOut(dataOut), .dataOutEnN(dataOutEnN));
   function automatic logic [1:0] segExp(input logic [2:0] t);
      return (t == 3'h4) ? 2'h1 : (t == 3'h7) ? 2'h2 : 2'h0;
   endfunction
   task automatic setCol(input logic [6:0] c);
      host.put(1'b0, {4'h0, c[3:0]});
      host.put(1'b0, {5'h02, c[6:4]});
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Whole run needs about 850 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      logic [7:0] r, x;
      logic       en;
      logic [6:0] c;
      logic [2:0] p;
      int         n;
      logic [7:0] pt [6] = '{8'h00, 8'h1f, 8'h9e, 8'he1, 8'h45, 8'h00};
      int         rat [4] = '{8, 16, 3, 4};
      void'($urandom(32'h6bca8d1a));
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK(deselectLevel, 8'h35, "deselect reset")
      `CHK(rowNonOverlapClks, 7'h03, "overlap reset")
      `CHK(segFloat, 2'h0, "float reset")
      x = $urandom;
      host.put(1'b0, 8'hdb);
      host.put(1'b0, x);
      `CHK(deselectLevel, x, "deselect")
      pt[5] = $urandom;
      foreach (pt[i]) begin
         host.put(1'b0, 8'hdc);
         host.put(1'b0, pt[i]);
         `CHK(periodByte, pt[i], "period")
         `CHK(rowNonOverlapClks, 7'(pt[i][4:0] * 3), "overlap")
         `CHK(segFloat, segExp(pt[i][7:5]), "float")
      end
      p = $urandom;
      c = 7'h7e;
      host.put(1'b0, {5'h16, p});
      setCol(c);
      for (int i = 0; i < 4; i++) begin
         x = $urandom;
         mem[{p, 7'(c + i)}] = x;
         host.put(1'b1, x);
         `CHK(column, 7'(c + i + 1), "write column")
      end
      `CHK(page, p, "page")
      for (int i = 0; i < 2; i++) begin
         displayOn = i[0];
         host.get(1'b0, r, en);
         `CHK(r[6:0], {~displayOn, 6'h0c}, "status")
         `CHK({en, column, page}, {1'b0, 7'(c + 4), p}, "status side")
      end
      setCol(c);
      host.get(1'b1, r, en);
      `CHK({r, column}, {8'h00, c}, "dummy read")
      for (int i = 0; i < 4; i++) begin
         host.get(1'b1, r, en);
         `CHK(r, mem[{p, 7'(c + i)}], "read data")
         `CHK(column, 7'(c + i + 1), "read column")
      end
      c = $urandom;
      setCol(c);
      host.get(1'b1, r, en);
      x = $urandom;
      // mode entered and closed as a pair
      host.put(1'b0, 8'he0);
      `CHK(rmwActive, 1'b1, "mode on")
      host.get(1'b1, r, en);
      `CHK(column, c, "mode read")
      host.put(1'b1, x);
      `CHK(column, 7'(c + 1), "mode write")
      host.get(1'b1, r, en);
      host.put(1'b0, 8'hee);
      `CHK({rmwActive, column}, {1'b0, c}, "mode end")
      setCol(c);
      host.get(1'b1, r, en);
      host.get(1'b1, r, en);
      `CHK(r, x, "mode data")
      serialMode = 1'b1;
      host.get(1'b1, r, en);
      `CHK({en, column}, {1'b1, 7'(c + 1)}, "serial read")
      serialMode = 1'b0;
      foreach (rat[k]) begin
         host.put(1'b0, 8'hd5);
         host.put(1'b0, 8'(k));
         n = 0;
         repeat (48) @(negedge mclk) n += (divClk === 1'b1);
         `CHK(n, 48 / rat[k], "divider")
      end
      test_done();
   end
endmodule
`default_nettype wire
